// [include/pwmtc_pkg.sv]
// package for the pwm timer compare core: register map, fields, resets
// assumes a 32-bit apb slave with word-aligned registers
package pwmtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0c;
  localparam logic [7:0] OFS_PERIOD  = 8'h10;
  localparam logic [7:0] OFS_PSHADOW = 8'h14;
  localparam logic [7:0] OFS_CMP0    = 8'h18;
  localparam logic [7:0] OFS_CSH0    = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // ctrl fields
  localparam int CTRL_CLKSEL_LSB = 0;
  localparam int CTRL_PRE_BIT    = 3;
  localparam int CTRL_ALIGN_BIT  = 4;
  localparam int CTRL_SSHOT_BIT  = 5;
  localparam int CTRL_MSEL_LSB   = 8;

  // command fields, write-one actions
  localparam int CMD_RUN_SET  = 0;
  localparam int CMD_RUN_CLR  = 1;
  localparam int CMD_CNT_CLR  = 2;
  localparam int CMD_STE_SET  = 3;
  localparam int CMD_STE_CLR  = 4;
  localparam int CMD_ST_SET   = 8;
  localparam int CMD_ST_CLR   = 12;

  // status fields
  localparam int STS_RUN_BIT  = 0;
  localparam int STS_DIR_BIT  = 1;
  localparam int STS_STE_BIT  = 2;
  localparam int STS_ST_LSB   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and constants
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET    = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam logic [15:0] CNT_STEP     = 16'h0001;
  localparam int          EXTRA_DIV_BITS = 8;
  localparam logic [3:0]  MSEL_CMP_MIN = 4'h1;
  localparam logic [3:0]  MSEL_CMP_MAX = 4'h3;

endpackage

// [rtl/pwmtc_core.sv]
// pwm timer compare core: 16-bit counter, period and three compare channels
// assumes an apb master on the module clock; outputs feed dead-time logic

// Summary of operation
// - edge mode wraps to zero after period
// - center mode, one-match down turns direction up
// - center mode, period-match up turns direction down
// - direction flag steers count, lags one cycle
// - write-one set and clear of transfer enable
// - transfer pulse on pm-up, om-down, or stopped
// - transfer copies period and compare shadows
// - transfer clears the transfer enable flag
// - counts while run flag set; set/clear commands
// - counter clear zeroes count only
// - single shot clears run at period end
// - equality comparator per channel
// - compare shadow moves only on transfer
// - software forces state bits set or clear
// - hardware changes state bits only while running
// - compare-match counting up sets state
// - zero-match with compare-match up sets state
// - compare-match counting down clears state
// - zero-match without compare-match up clears state
// - prescaler divides by two-power, optional 256
// - prescaler held reset while stopped
// - count writes ignored while running
// - one bit selects edge or center mode
module pwmtc_core #(
  parameter int NCH = 3
) (
  // clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_NRST,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // to output path
  output logic      [NCH-1:0]    O_STATE,
  output logic                   O_PERIOD_MATCH,
  output logic                   O_ZERO_MATCH,
  output logic                   O_DIR,
  output logic                   O_RUN
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_m_r;
  logic rst_n_r;

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        acc      = I_PSEL & I_PENABLE;
  wire        wr       = acc & I_PWRITE;
  wire [31:0] wd       = I_PWDATA;
  wire        wr_ctrl  = wr & (I_PADDR == pwmtc_pkg::OFS_CTRL);
  wire        wr_cmd   = wr & (I_PADDR == pwmtc_pkg::OFS_CMD);
  wire        wr_count = wr & (I_PADDR == pwmtc_pkg::OFS_COUNT);
  wire        wr_psh   = wr & (I_PADDR == pwmtc_pkg::OFS_PSHADOW);

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] b,
                                  input int n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n; k++)
      if (a == b + 8'(4 * k))
        hit = 1'b1;
    return hit;
  endfunction

  wire mapped = is_reg(I_PADDR, pwmtc_pkg::OFS_CTRL, 6)
              | is_reg(I_PADDR, pwmtc_pkg::OFS_CMP0, 2 * NCH);

  // single-cycle access phase; unmapped addresses answer with an error
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = acc & ~mapped;

  wire cmd_run_set = wr_cmd & wd[pwmtc_pkg::CMD_RUN_SET];
  wire cmd_run_clr = wr_cmd & wd[pwmtc_pkg::CMD_RUN_CLR];
  wire cmd_cnt_clr = wr_cmd & wd[pwmtc_pkg::CMD_CNT_CLR];
  wire cmd_ste_set = wr_cmd & wd[pwmtc_pkg::CMD_STE_SET];
  wire cmd_ste_clr = wr_cmd & wd[pwmtc_pkg::CMD_STE_CLR];
  wire [NCH-1:0] cmd_st_set = {NCH{wr_cmd}} & wd[pwmtc_pkg::CMD_ST_SET +: NCH];
  wire [NCH-1:0] cmd_st_clr = {NCH{wr_cmd}} & wd[pwmtc_pkg::CMD_ST_CLR +: NCH];

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic [2:0]       clock_divide_select_r;
  logic             extra_prescale_enable_r;
  logic             align_mode_select_r;
  logic             single_shot_enable_r;
  logic [4*NCH-1:0] channel_mode_select_r;

  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      clock_divide_select_r   <= 3'h0;
      extra_prescale_enable_r <= 1'b0;
      align_mode_select_r     <= 1'b0;
      single_shot_enable_r    <= 1'b0;
      channel_mode_select_r   <= '0;
    end
    else if (wr_ctrl)
    begin
      clock_divide_select_r   <= wd[pwmtc_pkg::CTRL_CLKSEL_LSB +: 3];
      extra_prescale_enable_r <= wd[pwmtc_pkg::CTRL_PRE_BIT];
      align_mode_select_r     <= wd[pwmtc_pkg::CTRL_ALIGN_BIT];
      single_shot_enable_r    <= wd[pwmtc_pkg::CTRL_SSHOT_BIT];
      channel_mode_select_r   <= wd[pwmtc_pkg::CTRL_MSEL_LSB +: 4*NCH];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  logic        counter_run_flag_r;
  logic [14:0] presc_r;

  // divider wraps at 2^(sel + 8*pre); tick on all-ones of the low bits
  wire [3:0]  div_exp  = 4'({1'b0, clock_divide_select_r})
                       + (extra_prescale_enable_r ?
                          4'(pwmtc_pkg::EXTRA_DIV_BITS) : 4'h0);
  wire [14:0] div_mask = 15'((16'h0001 << div_exp) - 16'h0001);
  wire        tick     = counter_run_flag_r
                       & ((presc_r & div_mask) == div_mask);

  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      presc_r <= 15'h0000;
    else if (!counter_run_flag_r)
      presc_r <= 15'h0000;
    else
      presc_r <= presc_r + 15'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, direction, matches
  logic [15:0] pwm_counter_r;
  logic [15:0] active_period_r;
  logic [15:0] period_shadow_r;
  logic        count_direction_flag_r;
  logic        shadow_transfer_enable_r;

  wire zero_match   = (pwm_counter_r == pwmtc_pkg::CNT_RESET);
  wire one_match    = (pwm_counter_r == pwmtc_pkg::CNT_ONE);
  wire period_match = (pwm_counter_r == active_period_r);
  wire center       = align_mode_select_r;
  wire up           = ~count_direction_flag_r;

  // period end: edge wraps after period, center arrives at zero going down
  wire single_shot_end = tick & single_shot_enable_r
                       & (center ? (~up & one_match)
                                 : period_match);

  wire shadow_transfer_pulse = shadow_transfer_enable_r
                             & ((period_match & up)
                              | (one_match & ~up)
                              | ~counter_run_flag_r);
  // stopped: no timer clock, so the transfer takes the module clock
  wire xfer = shadow_transfer_pulse & (tick | ~counter_run_flag_r);

  logic [15:0] cnt_nxt;
  logic        dir_nxt;

  always_comb
  begin
    cnt_nxt = pwm_counter_r;
    dir_nxt = count_direction_flag_r;
    if (tick)
    begin
      if (!center)
      begin
        dir_nxt = 1'b0;
        cnt_nxt = period_match ? pwmtc_pkg::CNT_RESET
                               : pwm_counter_r + pwmtc_pkg::CNT_STEP;
      end
      else
      begin
        // old direction applies this step; flag turns for the next
        cnt_nxt = up ? pwm_counter_r + pwmtc_pkg::CNT_STEP
                     : pwm_counter_r - pwmtc_pkg::CNT_STEP;
        if (up & period_match)
          dir_nxt = 1'b1;
        else if (~up & one_match)
          dir_nxt = 1'b0;
      end
    end
    if (wr_count & ~counter_run_flag_r)
      cnt_nxt = wd[15:0];
    if (cmd_cnt_clr)
      cnt_nxt = pwmtc_pkg::CNT_RESET;
  end

  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwm_counter_r          <= pwmtc_pkg::CNT_RESET;
      count_direction_flag_r <= 1'b0;
    end
    else
    begin
      pwm_counter_r          <= cnt_nxt;
      count_direction_flag_r <= dir_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run and transfer-enable flags
  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      counter_run_flag_r <= 1'b0;
    else if (cmd_run_set)
      counter_run_flag_r <= 1'b1;
    else if (cmd_run_clr | single_shot_end)
      counter_run_flag_r <= 1'b0;
  end

  // a software set in the transfer cycle survives the automatic clear
  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      shadow_transfer_enable_r <= 1'b0;
    else if (cmd_ste_set)
      shadow_transfer_enable_r <= 1'b1;
    else if (cmd_ste_clr | xfer)
      shadow_transfer_enable_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // period registers
  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      period_shadow_r <= pwmtc_pkg::PERIOD_RESET;
      active_period_r <= pwmtc_pkg::PERIOD_RESET;
    end
    else
    begin
      if (wr_psh)
        period_shadow_r <= wd[15:0];
      if (xfer)
        active_period_r <= period_shadow_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare channels
  logic [15:0]    active_compare_value_r [NCH];
  logic [15:0]    compare_shadow_value_r [NCH];
  logic [NCH-1:0] channel_state_bit_r;
  logic [NCH-1:0] channel_compare_match;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      wire [7:0] sh_ofs = 8'(pwmtc_pkg::OFS_CSH0 + 4 * g);
      wire [3:0] msel   = channel_mode_select_r[4*g +: 4];
      wire cmp_mode = (msel >= pwmtc_pkg::MSEL_CMP_MIN)
                    & (msel <= pwmtc_pkg::MSEL_CMP_MAX);
      wire cm   = channel_compare_match[g];
      wire hw   = tick & cmp_mode;
      wire hset = hw & up & cm;
      wire hclr = hw & ((~up & cm) | (up & zero_match & ~cm));
      logic st_nxt;

      assign channel_compare_match[g] = (pwm_counter_r
                                        == active_compare_value_r[g]);

      always_comb
      begin
        st_nxt = channel_state_bit_r[g];
        if (hclr)
          st_nxt = 1'b0;
        if (hset)
          st_nxt = 1'b1;
        if (cmd_st_clr[g])
          st_nxt = 1'b0;
        if (cmd_st_set[g])
          st_nxt = 1'b1;
      end

      always_ff @(posedge I_MCLK or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          compare_shadow_value_r[g] <= pwmtc_pkg::CMP_RESET;
          active_compare_value_r[g] <= pwmtc_pkg::CMP_RESET;
          channel_state_bit_r[g]    <= 1'b0;
        end
        else
        begin
          if (wr & (I_PADDR == sh_ofs))
            compare_shadow_value_r[g] <= wd[15:0];
          if (xfer)
            active_compare_value_r[g] <= compare_shadow_value_r[g];
          channel_state_bit_r[g] <= st_nxt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (I_PADDR)
      pwmtc_pkg::OFS_CTRL:
      begin
        rdata[pwmtc_pkg::CTRL_CLKSEL_LSB +: 3] = clock_divide_select_r;
        rdata[pwmtc_pkg::CTRL_PRE_BIT]   = extra_prescale_enable_r;
        rdata[pwmtc_pkg::CTRL_ALIGN_BIT] = align_mode_select_r;
        rdata[pwmtc_pkg::CTRL_SSHOT_BIT] = single_shot_enable_r;
        rdata[pwmtc_pkg::CTRL_MSEL_LSB +: 4*NCH] = channel_mode_select_r;
      end
      pwmtc_pkg::OFS_STATUS:
      begin
        rdata[pwmtc_pkg::STS_RUN_BIT] = counter_run_flag_r;
        rdata[pwmtc_pkg::STS_DIR_BIT] = count_direction_flag_r;
        rdata[pwmtc_pkg::STS_STE_BIT] = shadow_transfer_enable_r;
        rdata[pwmtc_pkg::STS_ST_LSB +: NCH] = channel_state_bit_r;
      end
      pwmtc_pkg::OFS_COUNT:   rdata[15:0] = pwm_counter_r;
      pwmtc_pkg::OFS_PERIOD:  rdata[15:0] = active_period_r;
      pwmtc_pkg::OFS_PSHADOW: rdata[15:0] = period_shadow_r;
      default:
      begin
        for (int k = 0; k < NCH; k++)
        begin
          if (I_PADDR == 8'(pwmtc_pkg::OFS_CMP0 + 4 * k))
            rdata[15:0] = active_compare_value_r[k];
          if (I_PADDR == 8'(pwmtc_pkg::OFS_CSH0 + 4 * k))
            rdata[15:0] = compare_shadow_value_r[k];
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      O_PRDATA <= 32'h0000_0000;
    else if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
      O_PRDATA <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to output path
  assign O_STATE        = channel_state_bit_r;
  assign O_PERIOD_MATCH = period_match;
  assign O_ZERO_MATCH   = zero_match;
  assign O_DIR          = count_direction_flag_r;
  assign O_RUN          = counter_run_flag_r;

endmodule

// [sim/pwmtc_core_asserts.sv]
// checker for the pwm timer compare core, bound to its ports
// assumes the apb map of pwmtc_pkg and a single module clock
module pwmtc_core_asserts #(
  parameter int NCH = 3
) (
  // clock and reset
  input wire logic            I_MCLK,
  input wire logic            I_NRST,
  // apb
  input wire logic            I_PSEL,
  input wire logic            I_PENABLE,
  input wire logic            I_PWRITE,
  input wire logic [7:0]      I_PADDR,
  input wire logic [31:0]     I_PWDATA,
  input wire logic [31:0]     O_PRDATA,
  input wire logic            O_PREADY,
  input wire logic            O_PSLVERR,
  // output path
  input wire logic [NCH-1:0]  O_STATE,
  input wire logic            O_PERIOD_MATCH,
  input wire logic            O_ZERO_MATCH,
  input wire logic            O_DIR,
  input wire logic            O_RUN
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] ctrl_r;
  logic       wr;
  logic       cmd_wr;
  logic       free_e;
  logic       free_c;

  ////////////////////////////////////////////////////////////////////////////
  // mirror of the mode bits; free means one tick per clock, no bus write
  assign wr     = I_PSEL && I_PENABLE && I_PWRITE;
  assign cmd_wr = wr && (I_PADDR == pwmtc_pkg::OFS_CMD);
  assign free_e = O_RUN && !wr && (ctrl_r[4:0] == 5'h00);
  assign free_c = O_RUN && !wr && (ctrl_r[4:0] == 5'h10);

  always_ff @(posedge I_MCLK or negedge I_NRST)
    if (!I_NRST)
      ctrl_r <= 6'h00;
    else if (wr && (I_PADDR == pwmtc_pkg::OFS_CTRL))
      ctrl_r <= I_PWDATA[5:0];

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  sequence s_peak;
    free_c && O_PERIOD_MATCH && !O_DIR ##1 free_c;
  endsequence
  sequence s_turn_down;
    O_DIR && !O_PERIOD_MATCH ##1 O_PERIOD_MATCH;
  endsequence

  a_edge_wrap_zero: assert property (
    free_e && O_PERIOD_MATCH |=> O_ZERO_MATCH && !O_DIR)
    else $error("edge mode did not wrap to zero");
  a_center_turn_down: assert property (
    s_peak |-> s_turn_down)
    else $error("center mode peak turn wrong");
  a_center_turn_up: assert property (
    free_c && O_DIR ##1 O_ZERO_MATCH |-> !O_DIR)
    else $error("direction not up at zero");
  a_shot_stop_edge: assert property (
    free_e && ctrl_r[5] && O_PERIOD_MATCH |=> !O_RUN && O_ZERO_MATCH)
    else $error("single shot did not stop");
  a_run_by_cmd: assert property (
    $rose(O_RUN) |-> $past(cmd_wr && I_PWDATA[0]))
    else $error("run set without command");
  a_clear_only_count: assert property (
    cmd_wr && I_PWDATA[2:0] == 3'b100 && !ctrl_r[5]
    |=> O_ZERO_MATCH && O_RUN == $past(O_RUN))
    else $error("counter clear misbehaved");
  a_state_hold_stop: assert property (
    !O_RUN && !cmd_wr |=> $stable(O_STATE))
    else $error("state changed while stopped");
  a_state_sw_set: assert property (
    cmd_wr |=> (O_STATE & $past(I_PWDATA[8 +: NCH]))
               == $past(I_PWDATA[8 +: NCH]))
    else $error("software state set lost");
  a_unmapped_err: assert property (
    I_PSEL && I_PENABLE && I_PADDR > 8'h2c |-> O_PSLVERR)
    else $error("no error on unmapped address");
endmodule

bind pwmtc_core pwmtc_core_asserts #(.NCH(NCH)) pwmtc_core_asserts_inst (
  .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_STATE(O_STATE),
  .O_PERIOD_MATCH(O_PERIOD_MATCH), .O_ZERO_MATCH(O_ZERO_MATCH),
  .O_DIR(O_DIR), .O_RUN(O_RUN));

// [sim/pwmtc_outpath_model.sv]
// output path stand-in: counts turn-on edges of the channel state bits
// assumes registered state levels on the module clock
module pwmtc_outpath_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // state bits from the core
  input  wire logic [2:0] i_state,
  // turn-on edges seen
  output logic      [7:0] o_rises
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] prev_r;

  // high-side switch turns on per rising state bit
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      prev_r  <= 3'h0;
      o_rises <= 8'h00;
    end
    else
    begin
      prev_r  <= i_state;
      o_rises <= o_rises + 8'($countones(i_state & ~prev_r));
    end
endmodule

// [sim/pwm_timer_compare_core_bench.sv]
// self-checking bench for the pwm timer compare core over apb
// assumes the bound checker and the output path model beside the core
`define CHK(n, e, s) \
  begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module pwm_timer_compare_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [2:0]  state;
  logic [7:0]  rises;
  logic [63:0] q[$];
  logic [31:0] seed = 32'h0000_0028;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #12.5 mclk = ~mclk;

  pwmtc_core pwmtc_core_inst (
    .I_MCLK(mclk), .I_NRST(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(), .O_STATE(state),
    .O_PERIOD_MATCH(), .O_ZERO_MATCH(), .O_DIR(), .O_RUN());
  pwmtc_outpath_model pwmtc_outpath_model_inst (
    .i_clk(mclk), .i_rst_n(rst_n), .i_state(state), .o_rises(rises));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // note the masked expectation, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    q.push_back({m, e & m});
    xfer(1'b0, a, 32'h0);
  endtask

  // single shot run with a count write that must be ignored
  task automatic ss_run(input logic [31:0] c, input int t1, input int t2);
    wr(pwmtc_pkg::OFS_CTRL, c);
    wr(pwmtc_pkg::OFS_CMD, 32'h1);
    wr(pwmtc_pkg::OFS_COUNT, 32'habcd);
    repeat (t1) @(posedge mclk);
    rd(pwmtc_pkg::OFS_STATUS, 32'h1, 32'h1);
    rd(pwmtc_pkg::OFS_COUNT, 32'h0, 32'hfff0);
    repeat (t2) @(posedge mclk);
    rd(pwmtc_pkg::OFS_STATUS, 32'h0, 32'h1);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      `CHK("prdata", q[0][31:0], prdata & q[0][63:32])
      void'(q.pop_front());
    end

  initial
  begin
    #500000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(pwmtc_pkg::OFS_STATUS, 32'h0, 32'hffffffff);
    rd(8'h30, 32'h0, 32'hffffffff);
    seed = xs(seed);
    wr(pwmtc_pkg::OFS_PSHADOW, {16'h0, seed[15:0]});
    wr(pwmtc_pkg::OFS_CSH0, {16'h0, seed[31:16]});
    rd(pwmtc_pkg::OFS_PERIOD, 32'h0, 32'hffff);
    wr(pwmtc_pkg::OFS_CMD, 32'h8);
    rd(pwmtc_pkg::OFS_PERIOD, {16'h0, seed[15:0]}, 32'hffff);
    rd(pwmtc_pkg::OFS_CMP0, {16'h0, seed[31:16]}, 32'hffff);
    rd(pwmtc_pkg::OFS_STATUS, 32'h0, 32'h4);
    // period 9; compares 3, 0 (full on) and 10 (never on)
    wr(pwmtc_pkg::OFS_PSHADOW, 32'h9);
    wr(pwmtc_pkg::OFS_CSH0, 32'h3);
    wr(pwmtc_pkg::OFS_CSH0 + 8'h04, 32'h0);
    wr(pwmtc_pkg::OFS_CSH0 + 8'h08, 32'ha);
    wr(pwmtc_pkg::OFS_CMD, 32'h8);
    rd(pwmtc_pkg::OFS_CMP0 + 8'h08, 32'ha, 32'hffff);
    wr(pwmtc_pkg::OFS_CMD, 32'h500);
    rd(pwmtc_pkg::OFS_STATUS, 32'h50, 32'h70);
    wr(pwmtc_pkg::OFS_CMD, 32'h7200);
    rd(pwmtc_pkg::OFS_STATUS, 32'h20, 32'h70);
    wr(pwmtc_pkg::OFS_CMD, 32'h7000);
    wr(pwmtc_pkg::OFS_COUNT, 32'h5);
    rd(pwmtc_pkg::OFS_COUNT, 32'h5, 32'hffff);
    wr(pwmtc_pkg::OFS_CMD, 32'h4);
    rd(pwmtc_pkg::OFS_COUNT, 32'h0, 32'hffff);
    // divide by 128: no tick lands before the reads
    wr(pwmtc_pkg::OFS_CTRL, 32'h7);
    wr(pwmtc_pkg::OFS_CMD, 32'h1);
    wr(pwmtc_pkg::OFS_CMD, 32'h4);
    rd(pwmtc_pkg::OFS_STATUS, 32'h1, 32'h1);
    rd(pwmtc_pkg::OFS_COUNT, 32'h0, 32'hffff);
    // running off the transfer points: enable must stay until cleared
    wr(pwmtc_pkg::OFS_CMD, 32'h8);
    rd(pwmtc_pkg::OFS_STATUS, 32'h4, 32'h4);
    wr(pwmtc_pkg::OFS_CMD, 32'h10);
    rd(pwmtc_pkg::OFS_STATUS, 32'h0, 32'h4);
    wr(pwmtc_pkg::OFS_CMD, 32'h2);
    wr(pwmtc_pkg::OFS_CMD, 32'h4);
    ss_run(32'h20, 3, 12);
    ss_run(32'h21, 8, 24);
    ss_run(32'h28, 2000, 1000);
    ss_run(32'h11120, 3, 12);
    rd(pwmtc_pkg::OFS_STATUS, 32'h30, 32'h70);
    wr(pwmtc_pkg::OFS_CMD, 32'h7000);
    ss_run(32'h11130, 10, 40);
    rd(pwmtc_pkg::OFS_STATUS, 32'h20, 32'h72);
    `CHK("rises", 8'h07, rises)
    print_verdict();
  end
endmodule
